// [bench/fes_host_model.sv]
// serial host model: select, serial clock and data lines of the sequencer
// assumes the bench calls send() between frames and keeps proto equal to the ctrl register
`timescale 1ns/1ns
module fes_host_model
	import fes_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic [1:0] proto,
	output logic            sel_n,
	output logic            sck,
	output logic [3:0]      serial_data_lines
);
	// ==========================================================
	// idle
	initial begin
		sel_n = 1'b1;
		sck = 1'b0;
		serial_data_lines = 4'h0;
	end

	// ==========================================================
	// frame: msb first; nbits may stop mid-byte to model a cut frame
	task automatic send(input logic [39:0] b, input int nbits);
		int w;
		w = (proto == PROTO_QUAD) ? 4 : (proto == PROTO_DUAL) ? 2 : 1;
		@(posedge ref_clk);
		sel_n <= 1'b0;
		for (int i = 0; i < nbits; i += w) begin
			@(posedge ref_clk);
			sck <= 1'b0;
			// unused lines toggle so a stale level is never mistaken for data
			case (w)
				4: serial_data_lines <= b[39-i -: 4];
				2: serial_data_lines <= {~serial_data_lines[3:2], b[39-i -: 2]};
				default: serial_data_lines <= {~serial_data_lines[3:1], b[39-i]};
			endcase
			repeat (2) @(posedge ref_clk);
			sck <= 1'b1;
			repeat (2) @(posedge ref_clk);
		end
		sck <= 1'b0;
		@(posedge ref_clk);
		sel_n <= 1'b1;
		serial_data_lines <= ~serial_data_lines;
	endtask
endmodule // fes_host_model

// [bench/test_flash_erase_suspend_sequencer.sv]
// self-checking bench of the erase/suspend sequencer, host model on the serial side
// assumes short erase, program and latency counts set below
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module test_flash_erase_suspend_sequencer
	import fes_pkg::*;
;
	localparam int SSE = 40;
	localparam int SE = 60;
	localparam int BE = 80;
	localparam int SL = 10;
	typedef struct {logic [7:0] op; logic [1:0] pr; logic [23:0] ea; logic [23:0] pa; int dur;} fes_tb_row_t;
	fes_tb_row_t rows [5] = '{'{OP_SSE_A, 2'h0, 24'h013abc, 24'h013000, SSE},
		'{OP_SSE_B, 2'h1, 24'h0004ff, 24'h000000, SSE}, '{OP_SE, 2'h2, 24'h025555, 24'h020000, SE},
		'{OP_BE_A, 2'h0, 24'h0, 24'h03f000, BE}, '{OP_BE_B, 2'h1, 24'h0, 24'h01f000, BE}};
	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic [1:0]  proto = 2'h0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] rd;
	wire         sel_n;
	wire         sck;
	wire  [3:0]  dq;
	wire  [31:0] reg_rdata;
	wire         status_wip;
	wire         status_wel;
	wire  [7:0]  flag_status;
	int          mismatches = 0;
	int          check_count = 0;
	int          cnt;

	always #10 ref_clk = ~ref_clk;

	fes_top #(.SSE_CYC(SSE), .SE_CYC(SE), .BE_CYC(BE), .PP_CYC(30), .SUSLAT_CYC(SL)) fes_top_inst (
		.ref_clk(ref_clk), .reset(reset), .sel_n(sel_n), .sck(sck), .serial_data_lines(dq),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .status_wip(status_wip), .status_wel(status_wel),
		.flag_status(flag_status));
	fes_host_model fes_host_model_inst (.ref_clk(ref_clk), .proto(proto), .sel_n(sel_n),
		.sck(sck), .serial_data_lines(dq));

	// ==========================================================
	// helpers
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rdr(input logic [7:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 rd = reg_rdata;
	endtask
	task automatic send(input logic [39:0] b, input int n);
		fes_host_model_inst.send(b, n);
	endtask
	task automatic idle();
		cnt = 0;
		while (status_wip !== 1'b0 && cnt < 2000) begin
			tick(1);
			cnt++;
		end
	endtask
	task automatic erase(input logic [7:0] op, input logic [23:0] a);
		if (op == OP_BE_A || op == OP_BE_B) send({op, 32'h0}, 8);
		else send({op, a, 8'h00}, 32);
	endtask
	task automatic prog(input logic [23:0] a);
		wr(REG_CMD, 32'h1);
		send({OP_PP, a, 8'h00}, 40);
		tick(2);
		idle();
	endtask
	task automatic mem(input logic [5:0] i, input logic [7:0] e);
		wr(REG_MEMADDR, {26'h0, i});
		rdr(REG_MEMDATA);
		`CHK(rd[7:0], e)
	endtask
	task automatic done(input string s);
		$display("test %s done", s);
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		end_sim();
	end

	// ==========================================================
	// main sequence
	initial begin
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		tick(1);
		`CHK({status_wip, status_wel, flag_status}, {2'b00, FSR_RESET})
		rdr(8'hfc);
		`CHK(rd, 32'h0)
		mem(6'h05, ERASED);
		done("reset");
		foreach (rows[k]) begin
			wr(REG_CTRL, {30'h0, rows[k].pr});
			proto <= rows[k].pr;
			prog(rows[k].pa);
			mem(rows[k].pa[17:12], 8'h00);
			wr(REG_CMD, 32'h1);
			erase(rows[k].op, rows[k].ea);
			tick(2);
			`CHK({status_wip, flag_status[FSR_READY]}, 2'b10)
			idle();
			`CHK(cnt inside {[rows[k].dur-5:rows[k].dur+1]}, 1'b1)
			`CHK({status_wel, flag_status}, {1'b0, FSR_RESET})
			mem(rows[k].pa[17:12], ERASED);
		end
		done("erase table");
		wr(REG_CTRL, 32'h0);
		proto <= 2'h0;
		erase(OP_SSE_A, 24'h0);
		tick(3);
		`CHK({status_wip, status_wel, flag_status}, {2'b00, FSR_RESET})
		wr(REG_CMD, 32'h1);
		send({OP_SSE_B, 32'h0}, 31);
		tick(3);
		`CHK({status_wip, status_wel, flag_status}, {2'b01, FSR_RESET})
		wr(REG_LOCK, 32'h1);
		erase(OP_SSE_A, 24'h000123);
		tick(3);
		`CHK({status_wip, status_wel, flag_status}, {2'b01, 8'ha2})
		wr(REG_CMD, 32'h2);
		erase(OP_BE_B, 24'h0);
		tick(3);
		`CHK({status_wip, status_wel, flag_status}, {2'b01, 8'ha2})
		wr(REG_CMD, 32'h2);
		wr(REG_LOCK, 32'h0);
		wr(REG_CTRL, 32'h8);
		erase(OP_SSE_A, 24'h0);
		tick(2);
		idle();
		`CHK({status_wel, flag_status}, {1'b0, 8'ha0})
		wr(REG_CMD, 32'h2);
		done("refusals");
		// nested suspend, quad so the short frames land well inside the counts
		wr(REG_CTRL, 32'h2);
		proto <= 2'h2;
		prog(24'h020000);
		wr(REG_CMD, 32'h1);
		erase(OP_SE, 24'h020000);
		tick(4);
		send({OP_SUSP, 32'h0}, 8);
		tick(2);
		`CHK(flag_status[FSR_ESUS], 1'b1)
		idle();
		`CHK(cnt inside {[SL-4:SL]}, 1'b1)
		`CHK({status_wip, flag_status}, {1'b0, 8'hc0})
		wr(REG_CMD, 32'h1);
		send({OP_PP, 24'h021000, 8'h00}, 40);
		tick(3);
		`CHK({status_wel, flag_status}, {1'b1, 8'hd0})
		wr(REG_LOCK, 32'h4);
		send({OP_PP, 24'h010000, 8'h00}, 40);
		tick(4);
		send({OP_SUSP, 32'h0}, 8);
		idle();
		tick(SL + 2);
		`CHK(flag_status, 8'hd4)
		send({OP_RES, 32'h0}, 8);
		tick(2);
		`CHK({status_wip, flag_status[7], flag_status[2], flag_status[6]}, 4'b1001)
		idle();
		mem(6'h10, 8'h00);
		send({OP_RES, 32'h0}, 8);
		tick(2);
		`CHK(status_wip, 1'b1)
		idle();
		mem(6'h20, ERASED);
		`CHK({status_wel, flag_status}, {1'b0, 8'h90})
		wr(REG_CMD, 32'h2);
		wr(REG_LOCK, 32'h0);
		send({OP_RES, 32'h0}, 8);
		tick(3);
		`CHK({status_wip, flag_status}, {1'b0, FSR_RESET})
		done("suspend nesting");
		wr(REG_CMD, 32'h1);
		erase(OP_SSE_A, 24'h001000);
		tick(22);
		send({OP_SUSP, 32'h0}, 8);
		tick(2);
		idle();
		`CHK({status_wel, flag_status}, {1'b0, FSR_RESET})
		wr(REG_CMD, 32'h1);
		erase(OP_SE, 24'h0);
		tick(4);
		send({OP_SUSP, 32'h0}, 8);
		tick(2);
		@(posedge ref_clk);
		reset <= 1'b1;
		proto <= 2'h0;
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		tick(1);
		`CHK({status_wip, status_wel, flag_status}, {2'b00, FSR_RESET})
		done("late suspend and reset");
		// four-byte address mode: a three-byte frame is ignored, the fourth byte places it
		wr(REG_CTRL, 32'h4);
		wr(REG_LOCK, 32'h8);
		wr(REG_CMD, 32'h1);
		send({OP_SSE_A, 32'h0003_0000}, 32);
		tick(3);
		`CHK({status_wip, status_wel, flag_status}, {2'b01, FSR_RESET})
		send({OP_SSE_A, 32'h0003_0000}, 40);
		tick(3);
		`CHK({status_wip, status_wel, flag_status}, {2'b01, 8'ha2})
		wr(REG_CMD, 32'h3);
		send({OP_SSE_A, 32'h0002_0000}, 40);
		tick(2);
		`CHK(status_wip, 1'b1)
		idle();
		`CHK({status_wel, flag_status}, {1'b0, FSR_RESET})
		done("address mode");
		end_sim();
	end
endmodule // test_flash_erase_suspend_sequencer

// [rtl/fes_pkg.sv]
// constants, opcodes, flag positions and state types of the erase/suspend sequencer
// assumes a 50 MHz core clock; the serial pins are sampled as synchronous inputs
// ==========================================================================
// Behaviour
// - an erase finished without timeout leaves every byte of the erased region reading all ones
// - erase with write-enable latch clear is ignored and sets no error flag
// - without select rising on a byte boundary nothing executes and flags stay
// - erase of a locked region is refused, latch stays set, flags 1 and 5 set
// - during erase controller-ready reads 0 and write-in-progress 1, cleared at end
// - every erase end, good or failed, clears the write-enable latch
// - an erase timeout clears the latch and sets the erase-error flag
// - erase is self-timed with separate subsector, sector and bulk durations
// - subsector 52h/20h, sector D8h, bulk C7h/60h are decoded
// - any address inside the region selects the whole region, bits taken on rising clock
// - bulk erase refused when any sector is locked, latch stays, flags 1 and 5
// - suspend is 75h; program suspend sets flag 2, erase suspend flag 6
// - flag 7 rises after the suspend latency; host trusts it only then
// - if the operation ends inside the latency it completes and clears flag 2 or 6
// - suspend state is volatile; flag status comes up as 80h
// - one nesting level; first resume continues program, second the erase
// - reads outside the suspended page work normally during program suspend
// - program to an erase-suspended sector is ignored, sets flag 4, latch unchanged; after bulk suspend only the sector of the last address is checked
// - resumed erase does not recheck locks changed during suspension
// - resume 7Ah ignored when nothing suspended, else busy until it completes
// - commands arrive on one, two or four data lines per protocol
package fes_pkg;

	// ======================================================================
	// timing
	localparam int CLK_MHZ      = 50;
	localparam int T_SSE_US     = 50;   // plain defaults, durations are device-specific
	localparam int T_SE_US      = 150;
	localparam int T_BE_US      = 1000;
	localparam int T_PP_US      = 10;
	localparam int T_SUSLAT_US  = 2;
	localparam int SSE_CYC_DEF  = T_SSE_US * CLK_MHZ;
	localparam int SE_CYC_DEF   = T_SE_US * CLK_MHZ;
	localparam int BE_CYC_DEF   = T_BE_US * CLK_MHZ;
	localparam int PP_CYC_DEF   = T_PP_US * CLK_MHZ;
	localparam int SUSLAT_CYC_DEF = T_SUSLAT_US * CLK_MHZ;
	localparam logic [31:0] CNT_ONE = 32'h0000_0001;

	// ======================================================================
	// opcodes
	localparam logic [7:0] OP_SSE_A = 8'h52;
	localparam logic [7:0] OP_SSE_B = 8'h20;
	localparam logic [7:0] OP_SE    = 8'hd8;
	localparam logic [7:0] OP_BE_A  = 8'hc7;
	localparam logic [7:0] OP_BE_B  = 8'h60;
	localparam logic [7:0] OP_PP    = 8'h02;
	localparam logic [7:0] OP_SUSP  = 8'h75;
	localparam logic [7:0] OP_RES   = 8'h7a;

	// ======================================================================
	// flag status bits and values
	localparam int FSR_READY = 7;
	localparam int FSR_ESUS  = 6;
	localparam int FSR_EERR  = 5;
	localparam int FSR_PERR  = 4;
	localparam int FSR_PSUS  = 2;
	localparam int FSR_PROT  = 1;
	localparam logic [7:0] FSR_RESET = 8'h80;
	localparam logic [7:0] ERASED    = 8'hff;

	// ======================================================================
	// serial framing
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] LEN_OPC   = 4'h1;
	localparam logic [3:0] ALEN3     = 4'h3;
	localparam logic [3:0] ALEN4     = 4'h4;
	localparam logic [3:0] LEN_MAX   = 4'hf;
	localparam logic [1:0] PROTO_DUAL = 2'h1;
	localparam logic [1:0] PROTO_QUAD = 2'h2;

	// ======================================================================
	// array geometry: one byte stands for each 4 KB subsector
	localparam int MEM_AW    = 6;
	localparam int MEM_DEPTH = 64;
	localparam int SUB_LSB   = 12;
	localparam int SEC_BITS  = 2;
	localparam int NUM_SEC   = 4;

	// ======================================================================
	// register port
	localparam int ADDR_W = 8;
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_CMD     = 8'h04;
	localparam logic [7:0] REG_LOCK    = 8'h08;
	localparam logic [7:0] REG_STATUS  = 8'h0c;
	localparam logic [7:0] REG_MEMADDR = 8'h10;
	localparam logic [7:0] REG_MEMDATA = 8'h14;
	localparam int CTRL_ADDR4_BIT = 2;
	localparam int CTRL_FAIL_BIT  = 3;
	localparam int CMD_SETWEL_BIT = 0;
	localparam int CMD_CLRERR_BIT = 1;
	localparam int STAT_WEL_BIT   = 1;
	localparam int STAT_FSR_LSB   = 8;

	typedef enum logic [1:0] {
		FES_IDLE = 2'b00,
		FES_RUN  = 2'b01,
		FES_SUSP = 2'b11
	} fes_state_t;

	typedef enum logic [1:0] {
		FES_OP_SSE = 2'h0,
		FES_OP_SE  = 2'h1,
		FES_OP_BE  = 2'h2,
		FES_OP_PP  = 2'h3
	} fes_op_t;

endpackage

// [rtl/fes_top.sv]
// erase / program-suspend / resume command sequencer of a serial NOR flash
// assumes sel_n, sck and data lines are synchronous to ref_clk and slower than it
`timescale 1ns/1ns
module fes_top
	import fes_pkg::*;
#(
	parameter int SSE_CYC    = SSE_CYC_DEF,
	parameter int SE_CYC     = SE_CYC_DEF,
	parameter int BE_CYC     = BE_CYC_DEF,
	parameter int PP_CYC     = PP_CYC_DEF,
	parameter int SUSLAT_CYC = SUSLAT_CYC_DEF
) (
	input  wire logic              ref_clk,
	input  wire logic              reset,
	input  wire logic              sel_n,
	input  wire logic              sck,
	input  wire logic [3:0]        serial_data_lines,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [31:0]       reg_rdata,
	output logic                   status_wip,
	output logic                   status_wel,
	output logic      [7:0]        flag_status
);

	// ======================================================================
	// serial receiver
	logic              sck_q;
	logic              sel_q;
	logic [7:0]        sh_q;
	logic [3:0]        bitpos_q;
	logic [3:0]        bytecnt_q;
	logic [7:0]        opcode_q;
	logic [31:0]       addr_q;
	logic [7:0]        data_q;
	logic [1:0]        proto_q;
	logic              addr4_q;
	logic              fail_q;
	logic [NUM_SEC-1:0] lock_q;
	logic [MEM_AW-1:0] memaddr_q;
	logic [7:0]        mem_q [MEM_DEPTH];

	wire       rise      = ~sel_n & sck & ~sck_q;
	wire       frame_end = sel_n & ~sel_q;
	wire [3:0] step      = (proto_q == PROTO_QUAD) ? 4'h4 :
	                       (proto_q == PROTO_DUAL) ? 4'h2 : 4'h1;
	wire [7:0] sh_next   = (proto_q == PROTO_QUAD) ? {sh_q[3:0], serial_data_lines} :
	                       (proto_q == PROTO_DUAL) ? {sh_q[5:0], serial_data_lines[1:0]} :
	                       {sh_q[6:0], serial_data_lines[0]};
	wire [3:0] bit_next  = bitpos_q + step;
	wire       byte_done = rise & (bit_next == BYTE_BITS);
	wire [3:0] alen      = addr4_q ? ALEN4 : ALEN3;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sck_q     <= 1'b0;
			sel_q     <= 1'b1;
			sh_q      <= 8'h00;
			bitpos_q  <= 4'h0;
			bytecnt_q <= 4'h0;
		end else begin
			sck_q <= sck;
			sel_q <= sel_n;
			if (frame_end) begin
				bitpos_q  <= 4'h0;
				bytecnt_q <= 4'h0;
			end else if (rise) begin
				sh_q     <= sh_next;
				bitpos_q <= byte_done ? 4'h0 : bit_next;
				if (byte_done && bytecnt_q != LEN_MAX)
					bytecnt_q <= bytecnt_q + LEN_OPC;
			end
		end
	end

	// address bits shift in on rising serial clock edges
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			opcode_q <= 8'h00;
			addr_q   <= 32'h0000_0000;
			data_q   <= 8'h00;
		end else if (byte_done) begin
			if (bytecnt_q == 4'h0)
				opcode_q <= sh_next;
			else if (bytecnt_q <= alen)
				addr_q <= {addr_q[23:0], sh_next};
			else if (bytecnt_q == alen + LEN_OPC)
				data_q <= sh_next;
		end
	end

	// ======================================================================
	// command decode, taken only when select rises on a byte boundary
	wire cmd_go   = frame_end & (bitpos_q == 4'h0);
	wire is_sse   = (opcode_q == OP_SSE_A) | (opcode_q == OP_SSE_B);
	wire is_se    = opcode_q == OP_SE;
	wire is_be    = (opcode_q == OP_BE_A) | (opcode_q == OP_BE_B);
	wire is_pp    = opcode_q == OP_PP;
	wire is_susp  = opcode_q == OP_SUSP;
	wire is_res   = opcode_q == OP_RES;
	wire len_one  = bytecnt_q == LEN_OPC;
	wire len_addr = bytecnt_q == alen + LEN_OPC;
	wire len_prog = bytecnt_q == alen + LEN_OPC + LEN_OPC;

	fes_state_t state_q;
	fes_op_t    op_q;
	fes_op_t    eop_q;
	logic [31:0] rem_q;
	logic [31:0] lat_q;
	logic [31:0] erem_q;
	logic [31:0] prem_q;
	logic [MEM_AW-1:0] tgt_q;
	logic [MEM_AW-1:0] etgt_q;
	logic [MEM_AW-1:0] ptgt_q;
	logic [7:0]  pdata_q;
	logic [7:0]  pdat_q;
	logic        epark_q;
	logic        ppark_q;
	logic        wip_q;
	logic        wel_q;
	logic [7:0]  fsr_q;

	// any address inside the region names the whole region
	wire [MEM_AW-1:0]   cmd_idx = addr_q[SUB_LSB +: MEM_AW];
	wire [SEC_BITS-1:0] cmd_sec = cmd_idx[MEM_AW-1 -: SEC_BITS];
	wire idle       = state_q == FES_IDLE;
	wire active     = ~idle;
	wire op_erase   = op_q != FES_OP_PP;
	wire erase_cmd  = cmd_go & (((is_sse | is_se) & len_addr) | (is_be & len_one));
	wire prot_e     = is_be ? (|lock_q) : lock_q[cmd_sec];
	wire erase_ctx  = erase_cmd & wel_q & idle & ~epark_q & ~ppark_q;
	wire erase_acc  = erase_ctx & ~prot_e;
	wire erase_ref  = erase_ctx & prot_e;
	wire prog_cmd   = cmd_go & is_pp & len_prog & idle & ~ppark_q;
	wire in_esus    = epark_q & (cmd_sec == etgt_q[MEM_AW-1 -: SEC_BITS]);
	wire prog_ign   = prog_cmd & in_esus;
	wire prog_ref   = prog_cmd & ~in_esus & wel_q & lock_q[cmd_sec];
	wire prog_acc   = prog_cmd & ~in_esus & wel_q & ~lock_q[cmd_sec];
	wire susp_acc   = cmd_go & is_susp & len_one & (state_q == FES_RUN);
	wire res_acc    = cmd_go & is_res & len_one & idle & (epark_q | ppark_q);
	wire fin        = active & (rem_q == CNT_ONE);
	// completion beats the latency when both land together
	wire park       = (state_q == FES_SUSP) & ~fin & (lat_q == CNT_ONE);
	wire [31:0] erase_len = is_be ? 32'(BE_CYC) : is_se ? 32'(SE_CYC) : 32'(SSE_CYC);
	wire fes_op_t erase_kind = is_be ? FES_OP_BE : is_se ? FES_OP_SE : FES_OP_SSE;

	// register port decode
	wire wr_ctrl   = reg_wr & (reg_addr == REG_CTRL);
	wire wr_cmd    = reg_wr & (reg_addr == REG_CMD);
	wire set_wel   = wr_cmd & reg_wdata[CMD_SETWEL_BIT];
	wire clr_err   = wr_cmd & reg_wdata[CMD_CLRERR_BIT];

	// ======================================================================
	// sequencer
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_q <= FES_IDLE;
			op_q    <= FES_OP_SSE;
			eop_q   <= FES_OP_SSE;
			rem_q   <= 32'h0000_0000;
			lat_q   <= 32'h0000_0000;
			erem_q  <= 32'h0000_0000;
			prem_q  <= 32'h0000_0000;
			tgt_q   <= '0;
			etgt_q  <= '0;
			ptgt_q  <= '0;
			pdata_q <= ERASED;
			pdat_q  <= ERASED;
			epark_q <= 1'b0;
			ppark_q <= 1'b0;
			wip_q   <= 1'b0;
			wel_q   <= 1'b0;
			fsr_q   <= FSR_RESET;
		end else begin
			if (active)
				rem_q <= rem_q - CNT_ONE;
			if (state_q == FES_SUSP)
				lat_q <= lat_q - CNT_ONE;
			// software clear first so a hardware set in the same cycle wins
			if (clr_err) begin
				fsr_q[FSR_EERR] <= 1'b0;
				fsr_q[FSR_PERR] <= 1'b0;
				fsr_q[FSR_PROT] <= 1'b0;
			end
			if (fin) begin
				state_q <= FES_IDLE;
				wip_q   <= 1'b0;
				wel_q   <= 1'b0;
				fsr_q[FSR_READY] <= 1'b1;
				if (op_erase) begin
					fsr_q[FSR_ESUS] <= 1'b0;
					if (fail_q)
						fsr_q[FSR_EERR] <= 1'b1;
				end else begin
					fsr_q[FSR_PSUS] <= 1'b0;
				end
			end else if (park) begin
				state_q <= FES_IDLE;
				wip_q   <= 1'b0;
				fsr_q[FSR_READY] <= 1'b1;
				if (op_erase) begin
					epark_q <= 1'b1;
					erem_q  <= rem_q - CNT_ONE;
					etgt_q  <= tgt_q;
					eop_q   <= op_q;
				end else begin
					ppark_q <= 1'b1;
					prem_q  <= rem_q - CNT_ONE;
					ptgt_q  <= tgt_q;
					pdat_q  <= pdata_q;
				end
			end else if (susp_acc) begin
				state_q <= FES_SUSP;
				lat_q   <= 32'(SUSLAT_CYC);
				if (op_erase)
					fsr_q[FSR_ESUS] <= 1'b1;
				else
					fsr_q[FSR_PSUS] <= 1'b1;
			end
			if (erase_acc) begin
				state_q <= FES_RUN;
				op_q    <= erase_kind;
				rem_q   <= erase_len;
				tgt_q   <= cmd_idx;
				wip_q   <= 1'b1;
				fsr_q[FSR_READY] <= 1'b0;
			end else if (erase_ref) begin
				fsr_q[FSR_PROT] <= 1'b1;
				fsr_q[FSR_EERR] <= 1'b1;
			end else if (prog_ign) begin
				fsr_q[FSR_PERR] <= 1'b1;
			end else if (prog_ref) begin
				fsr_q[FSR_PROT] <= 1'b1;
				fsr_q[FSR_PERR] <= 1'b1;
			end else if (prog_acc) begin
				state_q <= FES_RUN;
				op_q    <= FES_OP_PP;
				rem_q   <= 32'(PP_CYC);
				tgt_q   <= cmd_idx;
				pdata_q <= data_q;
				wip_q   <= 1'b1;
				fsr_q[FSR_READY] <= 1'b0;
			end else if (res_acc) begin
				// no lock check here: the resumed erase keeps its original target
				state_q <= FES_RUN;
				wip_q   <= 1'b1;
				fsr_q[FSR_READY] <= 1'b0;
				if (ppark_q) begin
					ppark_q <= 1'b0;
					op_q    <= FES_OP_PP;
					rem_q   <= prem_q;
					tgt_q   <= ptgt_q;
					pdata_q <= pdat_q;
					fsr_q[FSR_PSUS] <= 1'b0;
				end else begin
					epark_q <= 1'b0;
					op_q    <= eop_q;
					rem_q   <= erem_q;
					tgt_q   <= etgt_q;
					fsr_q[FSR_ESUS] <= 1'b0;
				end
			end
			if (set_wel)
				wel_q <= 1'b1;
		end
	end

	// ======================================================================
	// array: each subsector byte is erased on completion without timeout, or programmed on completion
	wire erase_wr = fin & op_erase & ~fail_q;
	wire prog_wr  = fin & ~op_erase;

	genvar gi;
	generate
		for (gi = 0; gi < MEM_DEPTH; gi++) begin : g_mem
			wire [MEM_AW-1:0] idx = MEM_AW'(gi);
			wire hit = (op_q == FES_OP_BE) |
			           ((op_q == FES_OP_SSE) & (tgt_q == idx)) |
			           ((op_q == FES_OP_SE) &
			            (tgt_q[MEM_AW-1 -: SEC_BITS] == idx[MEM_AW-1 -: SEC_BITS]));
			always_ff @(posedge ref_clk) begin
				if (reset)
					mem_q[gi] <= ERASED;
				else if (erase_wr && hit)
					mem_q[gi] <= ERASED;
				else if (prog_wr && tgt_q == idx)
					mem_q[gi] <= mem_q[gi] & pdata_q;
			end
		end
	endgenerate

	// ======================================================================
	// register port
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			proto_q   <= 2'h0;
			addr4_q   <= 1'b0;
			fail_q    <= 1'b0;
			lock_q    <= '0;
			memaddr_q <= '0;
		end else begin
			if (wr_ctrl) begin
				proto_q <= reg_wdata[1:0];
				addr4_q <= reg_wdata[CTRL_ADDR4_BIT];
				fail_q  <= reg_wdata[CTRL_FAIL_BIT];
			end
			if (reg_wr && reg_addr == REG_LOCK)
				lock_q <= reg_wdata[NUM_SEC-1:0];
			if (reg_wr && reg_addr == REG_MEMADDR)
				memaddr_q <= reg_wdata[MEM_AW-1:0];
		end
	end

	// reads of unsuspended regions are plain array reads
	wire [31:0] ctrl_rd = 32'(proto_q) | (32'(addr4_q) << CTRL_ADDR4_BIT) |
	                      (32'(fail_q) << CTRL_FAIL_BIT);
	wire [31:0] stat_rd = 32'(wip_q) | (32'(wel_q) << STAT_WEL_BIT) |
	                      (32'(fsr_q) << STAT_FSR_LSB);
	wire [31:0] rd_mux  = (reg_addr == REG_CTRL)    ? ctrl_rd :
	                      (reg_addr == REG_LOCK)    ? 32'(lock_q) :
	                      (reg_addr == REG_STATUS)  ? stat_rd :
	                      (reg_addr == REG_MEMADDR) ? 32'(memaddr_q) :
	                      (reg_addr == REG_MEMDATA) ? 32'(mem_q[memaddr_q]) :
	                      32'h0000_0000;

	always_ff @(posedge ref_clk) begin
		if (reset)
			reg_rdata <= 32'h0000_0000;
		else
			reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
	end

	assign status_wip  = wip_q;
	assign status_wel  = wel_q;
	assign flag_status = fsr_q;

	// ======================================================================
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	a_wel_gate_erase: assert property (erase_cmd && !wel_q && idle && !clr_err
		|=> state_q == FES_IDLE && fsr_q == $past(fsr_q))
		else $error("erase without write enable was not ignored");
	a_start_needs_frame: assert property ($rose(wip_q) |-> $past(cmd_go))
		else $error("operation started without a complete frame");
	a_prot_refuse: assert property (erase_ref |=>
		fsr_q[FSR_PROT] && fsr_q[FSR_EERR] && wel_q && state_q == FES_IDLE)
		else $error("protected erase not refused correctly");
	a_busy_flags: assert property (state_q != FES_IDLE |-> wip_q && !fsr_q[FSR_READY])
		else $error("busy flags wrong while running");
	a_fin_clears_wel: assert property (fin && !set_wel |=> !wel_q && !wip_q)
		else $error("finish did not clear latch and busy");
	a_timeout_err: assert property (fin && op_erase && fail_q |=> fsr_q[FSR_EERR])
		else $error("erase timeout did not set error");
	a_sse_length: assert property (erase_acc && is_sse |=> rem_q == 32'(SSE_CYC))
		else $error("subsector erase duration not loaded");
	a_erase_ones: assert property (erase_wr && op_q == FES_OP_SSE |=>
		mem_q[$past(tgt_q)] == ERASED)
		else $error("erased byte not all ones");
	// a finish within two cycles legally clears the flag again, so leave that case out
	a_susp_flag: assert property (susp_acc && op_erase &&
		rem_q > CNT_ONE + CNT_ONE |=> fsr_q[FSR_ESUS] [*2])
		else $error("erase suspend flag not set");
	a_park_ready: assert property (park |=> fsr_q[FSR_READY] && !wip_q)
		else $error("suspended without ready");
	a_early_finish: assert property (fin && state_q == FES_SUSP && op_erase
		|=> !fsr_q[FSR_ESUS] && !epark_q)
		else $error("late suspend did not complete the erase");
	a_resume_order: assert property (res_acc && ppark_q |=>
		op_q == FES_OP_PP && epark_q == $past(epark_q))
		else $error("resume order wrong");
	a_prog_in_esus: assert property (prog_ign && !set_wel |=>
		fsr_q[FSR_PERR] && wel_q == $past(wel_q) && state_q == FES_IDLE)
		else $error("program to suspended sector not ignored");
	a_resume_idle: assert property (cmd_go && is_res && idle &&
		!epark_q && !ppark_q |=> state_q == FES_IDLE)
		else $error("resume with nothing suspended was not ignored");

	c_erase_done: cover property (erase_acc ##[1:1000] (fin && op_erase));
	c_erase_park: cover property (park && op_erase);
	c_nested:     cover property (epark_q && ppark_q);
	c_refused:    cover property (erase_ref);

endmodule // fes_top
